// >>> core_flags_stack_interrupt_vectoring.sv
// Overview of operation
// RULE_01: no interrupt while global enable clear
// RULE_02: entry clears enable, return sets it
// RULE_03: bit 6 is bit-copy store
// RULE_04: bit 5 holds half carry
// RULE_05: bit 4 always negative xor overflow
// RULE_06: bit 3 holds overflow
// RULE_07: bits 2,1,0 negative, zero, carry
// RULE_08: handlers save and restore flags themselves
// RULE_09: flags at i/o location 0x3f
// RULE_10: eleven-bit pointer, high byte three bits
// RULE_11: push stores then decrements by one
// RULE_12: call or entry pushes two, minus two
// RULE_13: each popped byte increments by one
// RULE_14: software sets pointer above 0x60 first
// RULE_15: seventeen sources, each with enable
// RULE_16: vectors two words apart from zero
// RULE_17: lowest vector wins, reset first
// RULE_18: every reset cause uses reset vector
// RULE_19: fixed source order of vectors
// RULE_20: boot fuse moves reset target
// RULE_21: write-one clears never lose events
// RULE_22: entry is one atomic sequence
// RULE_23: requests stay latched until serviced
`timescale 1ns/100ps
`default_nettype none
module core_flags_stack_interrupt_vectoring
   import core_flags_pkg::*;
#(
   parameter logic [12:0] BOOT_START = BOOT_START_DEF
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RSTN_I,
   // i/o register port
   input wire logic [5:0] IO_ADDR_I,
   input wire logic IO_WE_I,
   input wire logic IO_RE_I,
   input wire logic [7:0] IO_WDATA_I,
   output logic [7:0] IO_RDATA_O,
   // alu flag updates
   input wire logic [7:0] ALU_FLAG_WE_I,
   input wire logic [7:0] ALU_FLAG_I,
   // bit copy
   input wire logic BIT_STORE_INSTRUCTION_I,
   input wire logic BIT_STORE_VAL_I,
   output logic BIT_LOAD_VAL_O,
   // stack operations
   input wire logic PUSH_I,
   input wire logic [7:0] PUSH_DATA_I,
   input wire logic POP_I,
   input wire logic CALL_I,
   input wire logic [12:0] RET_PC_I,
   input wire logic RETURN_FROM_INTERRUPT_I,
   output logic STACK_WE_O,
   output logic STACK_RE_O,
   output logic [10:0] STACK_ADDR_O,
   output logic [7:0] STACK_WDATA_O,
   output logic [10:0] STACK_POINTER_O,
   // interrupt sources
   input wire logic INSTR_DONE_I,
   input wire logic [16:0] IRQ_REQ_I,
   input wire logic [16:0] IRQ_EN_I,
   input wire logic [16:0] IRQ_CLR_I,
   input wire logic BOOT_RESET_FUSE_I,
   output logic [16:0] IRQ_PEND_O,
   // program counter control
   output logic PC_LOAD_O,
   output logic [12:0] PC_VALUE_O,
   output logic BUSY_O,
   output logic [7:0] FLAGS_O
);
   // ==========================================
   // declarations
   seq_state_type state_q;
   seq_state_type state_d;
   logic [7:0] flags_q;
   logic [7:0] flags_view;
   logic [10:0] sp_q;
   logic [7:0] rdata_q;
   logic we_q;
   logic re_q;
   logic [10:0] addr_q;
   logic [7:0] wdata_q;
   logic pc_load_q;
   logic [12:0] pc_value_q;
   logic [12:0] ret_pc_q;
   logic [12:0] vector_q;
   logic irq_entry_q;
   logic fuse_m_q;
   logic fuse_s_q;
   logic [IRQ_N-1:0] pend;
   logic [IRQ_N-1:0] gated;
   logic [IRQ_N-1:0] win_hot;
   logic [IRQ_N-1:0] ack;
   logic win_valid;
   logic [IDX_W-1:0] win_idx;
   logic take;
   logic wr_flags;
   logic wr_spl;
   logic wr_sph;
   logic [12:0] win_vector;
   // ==========================================
   // fuse pin synchroniser, free running so it settles during reset
   always_ff @(posedge CLK_I) begin
      fuse_m_q <= BOOT_RESET_FUSE_I;
      fuse_s_q <= fuse_m_q;
   end
   // ==========================================
   // i/o decode
   assign wr_flags = IO_WE_I &&
      (IO_ADDR_I == CORE_FLAG_REGISTER_OFS); // RULE_09
   assign wr_spl = IO_WE_I &&
      (IO_ADDR_I == STACK_POINTER_LOW_OFS);
   assign wr_sph = IO_WE_I &&
      (IO_ADDR_I == STACK_POINTER_HIGH_OFS);
   // ==========================================
   // pending requests
   for (genvar g = 0; g < IRQ_N; g++) begin : g_pend
      irq_pending_cell u_cell (
         .clk_i(CLK_I),
         .rstn_i(RSTN_I),
         .set_i(IRQ_REQ_I[g]),
         .ack_i(ack[g]),
         .clr_i(IRQ_CLR_I[g]),
         .pend_o(pend[g])
      );
   end
   assign gated = pend & IRQ_EN_I; // RULE_15
   irq_priority u_prio (
      .req_i(gated),
      .valid_o(win_valid),
      .idx_o(win_idx),
      .onehot_o(win_hot)
   );
   // source index i sits at vector 2*(i+1)
   assign win_vector = VECTOR_STEP *
      (13'(win_idx) + 13'd1); // RULE_16 RULE_19
   assign take = (state_q == ST_RUN) && INSTR_DONE_I &&
      flags_q[FLAG_GIE] && win_valid; // RULE_01 RULE_22
   assign ack = take ? win_hot : '0;
   // ==========================================
   // entry / call sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_BOOT: begin
            state_d = ST_RUN;
         end
         ST_RUN: begin
            if (take || CALL_I) begin
               state_d = ST_PUSH_LO;
            end
         end
         ST_PUSH_LO: begin
            state_d = ST_PUSH_HI;
         end
         ST_PUSH_HI: begin
            state_d = irq_entry_q ? ST_VECTOR : ST_RUN;
         end
         ST_VECTOR: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         state_q <= ST_BOOT;
      end else begin
         state_q <= state_d;
      end
   end
   // ==========================================
   // return address and vector capture
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         ret_pc_q <= RESET_VECTOR;
         vector_q <= RESET_VECTOR;
         irq_entry_q <= 1'b0;
      end else if (state_q == ST_RUN) begin
         if (take) begin
            ret_pc_q <= RET_PC_I; // RULE_22
            vector_q <= win_vector;
            irq_entry_q <= 1'b1;
         end else if (CALL_I) begin
            ret_pc_q <= RET_PC_I;
            irq_entry_q <= 1'b0;
         end
      end
   end
   // ==========================================
   // program counter load
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         pc_load_q <= 1'b0;
         pc_value_q <= RESET_VECTOR;
      end else begin
         pc_load_q <= 1'b0;
         if (state_q == ST_BOOT) begin
            pc_load_q <= 1'b1; // RULE_18
            pc_value_q <= fuse_s_q ? BOOT_START :
               RESET_VECTOR; // RULE_20
         end else if (state_q == ST_VECTOR) begin
            pc_load_q <= 1'b1;
            pc_value_q <= vector_q; // RULE_17
         end
      end
   end
   // ==========================================
   // stack pointer and stack access
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         sp_q <= SP_RST; // RULE_14
         we_q <= 1'b0;
         re_q <= 1'b0;
         addr_q <= SP_RST;
         wdata_q <= 8'h00;
      end else begin
         we_q <= 1'b0;
         re_q <= 1'b0;
         if (state_q == ST_PUSH_LO) begin
            we_q <= 1'b1;
            addr_q <= sp_q;
            wdata_q <= ret_pc_q[7:0];
            sp_q <= sp_q - 11'd1; // RULE_12
         end else if (state_q == ST_PUSH_HI) begin
            we_q <= 1'b1;
            addr_q <= sp_q;
            wdata_q <= {3'h0, ret_pc_q[12:8]};
            sp_q <= sp_q - 11'd1; // RULE_12
         end else if (PUSH_I) begin
            we_q <= 1'b1;
            addr_q <= sp_q;
            wdata_q <= PUSH_DATA_I;
            sp_q <= sp_q - 11'd1; // RULE_11
         end else if (POP_I) begin
            re_q <= 1'b1;
            addr_q <= sp_q + 11'd1;
            sp_q <= sp_q + 11'd1; // RULE_13
         end else if (wr_spl) begin
            sp_q[7:0] <= IO_WDATA_I; // RULE_10
         end else if (wr_sph) begin
            sp_q[10:8] <= IO_WDATA_I[2:0]; // RULE_10
         end
      end
   end
   // ==========================================
   // flag register
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         flags_q <= FLAGS_RST;
      end else begin
         if (wr_flags) begin
            flags_q <= IO_WDATA_I;
         end else begin
            for (int b = 0; b < FLAG_W; b++) begin
               if (ALU_FLAG_WE_I[b]) begin
                  // RULE_04 RULE_06 RULE_07
                  flags_q[b] <= ALU_FLAG_I[b];
               end
            end
            if (BIT_STORE_INSTRUCTION_I) begin
               flags_q[FLAG_T] <= BIT_STORE_VAL_I; // RULE_03
            end
         end
         if (take) begin
            flags_q[FLAG_GIE] <= 1'b0; // RULE_02
         end else if (RETURN_FROM_INTERRUPT_I) begin
            flags_q[FLAG_GIE] <= 1'b1; // RULE_02
         end
      end
   end
   always_comb begin
      flags_view = flags_q;
      flags_view[FLAG_S] = flags_q[FLAG_N] ^
         flags_q[FLAG_V]; // RULE_05
   end
   // ==========================================
   // i/o read data
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         rdata_q <= 8'h00;
      end else if (IO_RE_I) begin
         unique case (IO_ADDR_I)
            CORE_FLAG_REGISTER_OFS: begin
               rdata_q <= flags_view;
            end
            STACK_POINTER_LOW_OFS: begin
               rdata_q <= sp_q[7:0];
            end
            STACK_POINTER_HIGH_OFS: begin
               rdata_q <= {5'h00, sp_q[10:8]}; // RULE_10
            end
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end
   end
   // ==========================================
   // outputs
   assign IO_RDATA_O = rdata_q;
   assign BIT_LOAD_VAL_O = flags_q[FLAG_T]; // RULE_03
   assign STACK_WE_O = we_q;
   assign STACK_RE_O = re_q;
   assign STACK_ADDR_O = addr_q;
   assign STACK_WDATA_O = wdata_q;
   assign STACK_POINTER_O = sp_q;
   assign IRQ_PEND_O = pend;
   assign PC_LOAD_O = pc_load_q;
   assign PC_VALUE_O = pc_value_q;
   assign BUSY_O = (state_q != ST_RUN);
   assign FLAGS_O = flags_view;
endmodule : core_flags_stack_interrupt_vectoring
`default_nettype wire

// >>> core_flags_pkg.sv
package core_flags_pkg;
   // ==========================================
   // widths
   localparam int FLAG_W = 8;
   localparam int SP_W = 11;
   localparam int PC_W = 13;
   localparam int IRQ_N = 17;
   localparam int IDX_W = 5;
   // ==========================================
   // i/o register map
   localparam logic [5:0] STACK_POINTER_LOW_OFS = 6'h3d;
   localparam logic [5:0] STACK_POINTER_HIGH_OFS = 6'h3e;
   localparam logic [5:0] CORE_FLAG_REGISTER_OFS = 6'h3f;
   localparam logic [7:0] CORE_FLAG_DATA_ADDR = 8'h5f;
   // ==========================================
   // reset values
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [10:0] SP_RST = 11'h000;
   localparam logic [2:0] SPH_WR_MASK_W = 3'h3;
   // ==========================================
   // flag bit positions
   localparam int FLAG_GIE = 7;
   localparam int FLAG_T = 6;
   localparam int FLAG_H = 5;
   localparam int FLAG_S = 4;
   localparam int FLAG_V = 3;
   localparam int FLAG_N = 2;
   localparam int FLAG_Z = 1;
   localparam int FLAG_C = 0;
   // ==========================================
   // vectors, in program words
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] VECTOR_STEP = 13'h0002;
   localparam logic [12:0] BOOT_START_DEF = 13'h1f00;
   localparam logic [12:0] LAST_VECTOR = 13'h0022;
   // ==========================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_RUN = 3'b001,
      ST_PUSH_LO = 3'b010,
      ST_PUSH_HI = 3'b011,
      ST_VECTOR = 3'b100
   } seq_state_type;
endpackage : core_flags_pkg

// >>> irq_pending_cell.sv
`timescale 1ns/100ps
`default_nettype none
module irq_pending_cell (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // request events
   input wire logic set_i,
   input wire logic ack_i,
   input wire logic clr_i,
   // latched state
   output logic pend_o
);
   logic pend_q;
   // ==========================================
   // sticky request, set wins over clears
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pend_q <= 1'b0;
      end else if (set_i) begin
         pend_q <= 1'b1; // RULE_23
      end else if (ack_i || clr_i) begin
         pend_q <= 1'b0; // RULE_21
      end
   end
   assign pend_o = pend_q;
endmodule : irq_pending_cell
`default_nettype wire

// >>> irq_priority.sv
`timescale 1ns/100ps
`default_nettype none
module irq_priority
   import core_flags_pkg::*;
(
   // gated requests
   input wire logic [IRQ_N-1:0] req_i,
   // winner
   output logic valid_o,
   output logic [IDX_W-1:0] idx_o,
   output logic [IRQ_N-1:0] onehot_o
);
   // ==========================================
   // lowest index (lowest vector) wins
   always_comb begin
      valid_o = 1'b0;
      idx_o = '0;
      onehot_o = '0;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            valid_o = 1'b1; // RULE_17
            idx_o = IDX_W'(i);
            onehot_o = IRQ_N'(1) << i;
         end
      end
   end
endmodule : irq_priority
`default_nettype wire

// >>> stack_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module stack_ram_model (
   // clock
   input wire logic clk_i,
   // stack port
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [10:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem_q [2048];
   logic [7:0] last_q;
   // ==========================================
   // storage
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
      if (re_i) begin
         last_q <= mem_q[addr_i];
      end
   end
   // idle bus shows the inverse of the last read
   assign rdata_o = re_i ? mem_q[addr_i] : ~last_q;
endmodule : stack_ram_model
`default_nettype wire

// >>> core_flags_properties.sv
`timescale 1ns/100ps
`default_nettype none
module core_flags_properties
   import core_flags_pkg::*;
#(
   parameter logic [12:0] BOOT_START = BOOT_START_DEF
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RSTN_I,
   // i/o read port
   input wire logic [5:0] IO_ADDR_I,
   input wire logic IO_RE_I,
   input wire logic [7:0] IO_RDATA_O,
   // stack
   input wire logic PUSH_I,
   input wire logic POP_I,
   input wire logic CALL_I,
   input wire logic RETURN_FROM_INTERRUPT_I,
   input wire logic STACK_WE_O,
   input wire logic STACK_RE_O,
   input wire logic [10:0] STACK_POINTER_O,
   // vectoring and flags
   input wire logic PC_LOAD_O,
   input wire logic [12:0] PC_VALUE_O,
   input wire logic BUSY_O,
   input wire logic [7:0] FLAGS_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   // ==========================================
   // flags
   gie_block_a: assert property (
      !FLAGS_O[7] && !BUSY_O && !CALL_I |=> !BUSY_O)
      else $error("interrupt taken while disabled");
   take_clears_a: assert property (
      $rose(BUSY_O) && !$past(CALL_I) |-> !FLAGS_O[7])
      else $error("enable kept on entry");
   return_sets_a: assert property (
      RETURN_FROM_INTERRUPT_I && !FLAGS_O[7] |=> FLAGS_O[7])
      else $error("enable not set by return");
   sign_bit_a: assert property (
      IO_RE_I && IO_ADDR_I == CORE_FLAG_REGISTER_OFS |=>
      IO_RDATA_O[4] == (IO_RDATA_O[2] ^ IO_RDATA_O[3]))
      else $error("sign bit wrong");
   // ==========================================
   // stack and vectors
   push_dec_a: assert property (
      PUSH_I && !BUSY_O && !CALL_I |=> STACK_WE_O &&
      STACK_POINTER_O == $past(STACK_POINTER_O) - 11'h001)
      else $error("push pointer wrong");
   pop_inc_a: assert property (
      POP_I && !PUSH_I && !BUSY_O |=> STACK_RE_O &&
      STACK_POINTER_O == $past(STACK_POINTER_O) + 11'h001)
      else $error("pop pointer wrong");
   call_two_a: assert property (
      CALL_I && !BUSY_O |-> ##3
      STACK_POINTER_O == $past(STACK_POINTER_O, 3) - 11'h002)
      else $error("call pointer wrong");
   vector_range_a: assert property (
      PC_LOAD_O |-> !PC_VALUE_O[0] &&
      (PC_VALUE_O <= LAST_VECTOR || PC_VALUE_O == BOOT_START))
      else $error("vector out of table");
   last_vec_c: cover property (PC_LOAD_O && PC_VALUE_O == LAST_VECTOR);
   take_c: cover property ($rose(BUSY_O) && !$past(CALL_I));
   pop_c: cover property (STACK_RE_O);
endmodule : core_flags_properties
bind core_flags_stack_interrupt_vectoring core_flags_properties
   #(.BOOT_START(BOOT_START)) chk (.*);
`default_nettype wire

// >>> tb_core_flags_stack_interrupt_vectoring.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin \
   total_checks++; \
   if ((e) !== (s)) begin \
      failures++; \
      $display("MISMATCH %s exp %h seen %h", n, e, s); \
   end \
end
module tb_core_flags_stack_interrupt_vectoring
   import core_flags_pkg::*;
;
   logic CLK_I, RSTN_I, IO_WE_I, IO_RE_I, PUSH_I, POP_I, CALL_I;
   logic BIT_STORE_INSTRUCTION_I, BIT_STORE_VAL_I, BIT_LOAD_VAL_O;
   logic RETURN_FROM_INTERRUPT_I, INSTR_DONE_I, BOOT_RESET_FUSE_I;
   logic STACK_WE_O, STACK_RE_O, PC_LOAD_O, BUSY_O, re_d;
   logic [5:0] IO_ADDR_I;
   logic [7:0] IO_WDATA_I, IO_RDATA_O, ALU_FLAG_WE_I, ALU_FLAG_I;
   logic [7:0] PUSH_DATA_I, STACK_WDATA_O, FLAGS_O, mem_rd, fl;
   logic [7:0] shadow [2048];
   logic [10:0] STACK_ADDR_O, STACK_POINTER_O, sp;
   logic [12:0] RET_PC_I, PC_VALUE_O;
   logic [16:0] IRQ_REQ_I, IRQ_EN_I, IRQ_CLR_I, IRQ_PEND_O;
   logic [21:0] eq [$];
   int failures, total_checks;
   core_flags_stack_interrupt_vectoring dut (.*);
   stack_ram_model ram (
      .clk_i(CLK_I),
      .we_i(STACK_WE_O),
      .re_i(STACK_RE_O),
      .addr_i(STACK_ADDR_O),
      .wdata_i(STACK_WDATA_O),
      .rdata_o(mem_rd)
   );
   initial begin
      CLK_I = 1'b0;
      forever #12.5 CLK_I = ~CLK_I;
   end
   // ==========================================
   // watcher
   task automatic see(input logic [21:0] v);
      logic [21:0] e;
      e = (eq.size() > 0) ? eq.pop_front() : ~v;
      `CHK("event", e, v)
   endtask : see
   always @(posedge CLK_I) re_d <= IO_RE_I && RSTN_I;
   always @(negedge CLK_I) begin
      if (RSTN_I && re_d) see({2'h0, 12'h000, IO_RDATA_O});
      if (RSTN_I && PC_LOAD_O) see({2'h1, 7'h00, PC_VALUE_O});
      if (RSTN_I && (STACK_WE_O || STACK_RE_O)) begin
         see({2'h2, STACK_RE_O, STACK_ADDR_O,
            STACK_RE_O ? mem_rd : STACK_WDATA_O});
      end
   end
   // ==========================================
   // drivers
   task automatic io(input logic w, input logic [5:0] a,
      input logic [7:0] d);
      if (!w) eq.push_back({2'h0, 12'h000, d});
      {IO_ADDR_I, IO_WDATA_I, IO_WE_I, IO_RE_I} <= {a, d, w, !w};
      @(posedge CLK_I);
      {IO_WE_I, IO_RE_I} <= 2'h0;
      @(posedge CLK_I);
   endtask : io
   task automatic stack_ret(input logic [12:0] pc);
      eq.push_back({3'h4, sp, pc[7:0]});
      eq.push_back({3'h4, sp - 11'h001, 3'h0, pc[12:8]});
      shadow[sp] = pc[7:0];
      shadow[sp - 11'h001] = {3'h0, pc[12:8]};
      sp = sp - 11'h002;
   endtask : stack_ret
   task automatic pops(input int n);
      repeat (n) begin
         POP_I <= 1'b1;
         @(posedge CLK_I);
         sp = sp + 11'h001;
         eq.push_back({3'h5, sp, shadow[sp]});
      end
      POP_I <= 1'b0;
   endtask : pops
   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic idle;
      int n;
      n = 0;
      repeat (2) @(posedge CLK_I);
      while (BUSY_O !== 1'b0 && n < 20) begin
         @(posedge CLK_I);
         n++;
      end
      if (n >= 20) begin
         failures++;
         close_out();
      end
   endtask : idle
   // ==========================================
   // sequence
   initial begin
      void'($urandom(59));
      {IO_WE_I, IO_RE_I, PUSH_I, POP_I, CALL_I, RSTN_I} = '0;
      {BIT_STORE_INSTRUCTION_I, BIT_STORE_VAL_I, BOOT_RESET_FUSE_I} = '0;
      {RETURN_FROM_INTERRUPT_I, IO_ADDR_I, IO_WDATA_I, RET_PC_I} = '0;
      {ALU_FLAG_WE_I, ALU_FLAG_I, PUSH_DATA_I} = '0;
      {IRQ_REQ_I, IRQ_EN_I, IRQ_CLR_I} = '0;
      INSTR_DONE_I = 1'b1;
      failures = 0;
      total_checks = 0;
      eq.push_back({2'h1, 7'h00, RESET_VECTOR});
      repeat (2) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      repeat (2) @(posedge CLK_I);
      io(0, STACK_POINTER_LOW_OFS, 8'h00);
      io(0, CORE_FLAG_REGISTER_OFS, FLAGS_RST);
      io(1, STACK_POINTER_HIGH_OFS, 8'hff);
      io(1, STACK_POINTER_LOW_OFS, 8'h5f);
      io(0, STACK_POINTER_HIGH_OFS, 8'h07);
      io(0, 6'h3c, 8'h00);
      sp = 11'h75f;
      repeat (4) begin
         fl = 8'($urandom);
         io(1, CORE_FLAG_REGISTER_OFS, fl);
         fl[4] = fl[2] ^ fl[3];
         io(0, CORE_FLAG_REGISTER_OFS, fl);
         ALU_FLAG_WE_I <= 8'($urandom) & 8'h2f;
         ALU_FLAG_I <= 8'($urandom);
         BIT_STORE_VAL_I <= 1'($urandom);
         BIT_STORE_INSTRUCTION_I <= 1'b1;
         @(posedge CLK_I);
         fl = (fl & ~ALU_FLAG_WE_I) | (ALU_FLAG_I & ALU_FLAG_WE_I);
         fl[6] = BIT_STORE_VAL_I;
         fl[4] = fl[2] ^ fl[3];
         {ALU_FLAG_WE_I, BIT_STORE_INSTRUCTION_I} <= '0;
         io(0, CORE_FLAG_REGISTER_OFS, fl);
         `CHK("bit_load", fl[6], BIT_LOAD_VAL_O)
         `CHK("flags", fl, FLAGS_O)
      end
      io(1, CORE_FLAG_REGISTER_OFS, 8'h00);
      repeat (3) begin
         PUSH_DATA_I <= 8'($urandom);
         PUSH_I <= 1'b1;
         @(posedge CLK_I);
         eq.push_back({3'h4, sp, PUSH_DATA_I});
         shadow[sp] = PUSH_DATA_I;
         sp = sp - 11'h001;
      end
      PUSH_I <= 1'b0;
      pops(3);
      RET_PC_I <= 13'($urandom);
      CALL_I <= 1'b1;
      @(posedge CLK_I);
      CALL_I <= 1'b0;
      stack_ret(RET_PC_I);
      idle();
      `CHK("sp", sp, STACK_POINTER_O)
      pops(2);
      IRQ_REQ_I <= 17'h0_0001;
      RETURN_FROM_INTERRUPT_I <= 1'b1;
      @(posedge CLK_I);
      {IRQ_REQ_I, RETURN_FROM_INTERRUPT_I} <= '0;
      repeat (3) @(posedge CLK_I);
      io(0, CORE_FLAG_REGISTER_OFS, 8'h80);
      IRQ_CLR_I <= 17'h0_0001;
      @(posedge CLK_I);
      IRQ_CLR_I <= '0;
      IRQ_EN_I <= '1;
      repeat (3) @(posedge CLK_I);
      io(1, CORE_FLAG_REGISTER_OFS, 8'h00);
      for (int i = 0; i < 17; i++) begin
         RET_PC_I <= 13'($urandom);
         IRQ_REQ_I <= (17'h0_0001 << i) | 17'h1_0000;
         @(posedge CLK_I);
         IRQ_REQ_I <= '0;
         repeat (3) @(posedge CLK_I);
         `CHK("pend", (17'h0_0001 << i) | 17'h1_0000, IRQ_PEND_O)
         stack_ret(RET_PC_I);
         eq.push_back({9'h080, 13'h0002 + 13'(2 * i)});
         RETURN_FROM_INTERRUPT_I <= 1'b1;
         @(posedge CLK_I);
         RETURN_FROM_INTERRUPT_I <= 1'b0;
         idle();
         `CHK("sp", sp, STACK_POINTER_O)
         io(0, CORE_FLAG_REGISTER_OFS, 8'h00);
         pops(2);
      end
      repeat (5) @(posedge CLK_I);
      BOOT_RESET_FUSE_I <= 1'b1;
      RSTN_I <= 1'b0;
      eq.push_back({2'h1, 7'h00, BOOT_START_DEF});
      repeat (3) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      repeat (3) @(posedge CLK_I);
      `CHK("sp_reset", SP_RST, STACK_POINTER_O)
      if (eq.size() != 0) failures++;
      close_out();
   end
endmodule : tb_core_flags_stack_interrupt_vectoring
`default_nettype wire
